/* File: inc/node_cfg_params.svh */
`ifndef NODE_CFG_PARAMS_SVH
`define NODE_CFG_PARAMS_SVH

// Register numbers (configuration access is by register number)
`define REG_SWITCH_CONFIGURATION      8'h04
`define REG_NODE_IDENTIFIER           8'h05
`define REG_CLOCK_MULTIPLIER_SETTINGS 8'h06
`define REG_SWITCH_CLOCK_DIVIDER      8'h07
`define REG_REFERENCE_CLOCK_DIVIDER   8'h08
`define REG_BOUNDARY_SCAN_DEVICE_ID   8'h09
`define REG_USER_CODE                 8'h0a
`define REG_ROUTE_DIRECTIONS_LOW      8'h0c
`define REG_ROUTE_DIRECTIONS_HIGH     8'h0d
`define REG_RESERVED_A                8'h10
`define REG_RESERVED_B                8'h11
`define REG_DEBUG_EVENT_ORIGIN        8'h1f

// Switch configuration fields
`define SWCFG_SSC_LOCK_BIT            31
`define SWCFG_CLKMUL_LOCK_BIT         8
`define SWCFG_HEADER_BIT              0

// Clock multiplier settings fields
`define CMS_NO_RESET_BIT              31
`define CMS_NO_RELOCK_WAIT_BIT        30
`define CMS_BYPASS_BIT                29
`define CMS_BOOT_JTAG_BIT             28
`define CMS_OD_HI                     25
`define CMS_OD_LO                     23
`define CMS_F_HI                      20
`define CMS_F_LO                      8
`define CMS_R_HI                      6
`define CMS_R_LO                      0

// User code fields
`define UC_OTP_HI                     31
`define UC_OTP_LO                     18
`define UC_METAL_HI                   17
`define UC_METAL_LO                   0

// Reset values
`define RST_SWITCH_CONFIGURATION      32'h0000_0000
`define RST_NODE_ID                   16'h0000
`define RST_CLOCK_MULTIPLIER          32'h0000_0000
`define RST_SWITCH_CLOCK_DIV          16'h0000
`define RST_REFERENCE_CLOCK_DIV       16'h0003
`define RST_DIRECTIONS                32'h0000_0000
`define RST_RESERVED_BITS             2'h0
`define RST_DEBUG_ORIGIN              5'h00

// Field masks
`define SWCFG_WRITE_MASK              32'h8000_0101
`define CMS_WRITE_MASK                32'hf3bf_ff7f
`define DBG_WRITE_MASK                5'h13

`endif

/* File: inc/node_cfg_pkg.sv */
package node_cfg_pkg;

  typedef logic [7:0]  reg_num_t;
  typedef logic [31:0] word_t;
  typedef logic [3:0]  direction_t;
  typedef logic [15:0] node_id_t;

endpackage : node_cfg_pkg

/* File: logic/switch_node_config_regs.sv */
`include "node_cfg_params.svh"

module switch_node_config_regs (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  // Configuration access
  input  wire logic                    cfg_wr,
  input  wire logic                    cfg_rd,
  input  wire node_cfg_pkg::reg_num_t  cfg_num,
  input  wire node_cfg_pkg::word_t     cfg_wdata,
  output node_cfg_pkg::word_t          cfg_rdata,
  output logic                         cfg_ack,
  output logic                         cfg_err,
  // Identity and debug inputs
  input  wire node_cfg_pkg::word_t     device_id_code,
  input  wire logic [13:0]             otp_user_code,
  input  wire logic [17:0]             metal_id_code,
  input  wire logic                    debug_event,
  input  wire logic [1:0]              debug_event_src,
  // Routing lookup
  input  wire node_cfg_pkg::node_id_t  dest_node_id,
  output node_cfg_pkg::direction_t     route_direction,
  output logic                         route_local,
  // Clock generation and control outputs
  output logic                         one_byte_headers,
  output node_cfg_pkg::node_id_t       node_id,
  output logic                         tile_reset,
  output logic                         skip_relock_wait,
  output logic                         multiplier_bypass,
  output logic                         boot_from_jtag,
  output logic [2:0]                   output_divider,
  output logic [12:0]                  feedback_ratio,
  output logic [6:0]                   input_divider,
  output logic [15:0]                  switch_clock_div,
  output logic [15:0]                  reference_clock_div
);

  import node_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  word_t       switch_configuration;
  word_t       clock_multiplier_settings;
  word_t       route_directions_low;
  word_t       route_directions_high;
  logic [1:0]  reserved_a;
  logic [1:0]  reserved_b;
  logic [4:0]  debug_event_origin;
  logic        next_tile_reset;
  logic        next_skip_relock;

  word_t       next_switch_configuration;
  node_id_t    next_node_id;
  word_t       next_clock_multiplier_settings;
  logic [15:0] next_switch_clock_div;
  logic [15:0] next_reference_clock_div;
  word_t       next_route_directions_low;
  word_t       next_route_directions_high;
  logic [1:0]  next_reserved_a;
  logic [1:0]  next_reserved_b;
  logic [4:0]  next_debug_event_origin;
  word_t       next_cfg_rdata;
  logic        next_cfg_ack;
  logic        next_cfg_err;

  logic        ssc_locked;
  logic        clkmul_locked;
  logic        known_num;
  logic        writable_num;

  ////////////////////////////////////////////////////////////////////////////
  // Write path

  assign ssc_locked    = switch_configuration[`SWCFG_SSC_LOCK_BIT];
  assign clkmul_locked = switch_configuration[`SWCFG_CLKMUL_LOCK_BIT];

  always_comb begin
    next_switch_configuration      = switch_configuration;
    next_node_id                   = node_id;
    next_clock_multiplier_settings = clock_multiplier_settings;
    next_switch_clock_div          = switch_clock_div;
    next_reference_clock_div       = reference_clock_div;
    next_route_directions_low      = route_directions_low;
    next_route_directions_high     = route_directions_high;
    next_reserved_a                = reserved_a;
    next_reserved_b                = reserved_b;
    next_debug_event_origin        = debug_event_origin;
    next_tile_reset                = 1'b0;
    next_skip_relock               = skip_relock_wait;
    // Writes blocked by the lock bit fall through and keep the old value.
    if (cfg_wr && !ssc_locked) begin
      if (cfg_num == `REG_SWITCH_CONFIGURATION) begin
        next_switch_configuration = cfg_wdata & `SWCFG_WRITE_MASK;
      end else if (cfg_num == `REG_NODE_IDENTIFIER) begin
        next_node_id = cfg_wdata[15:0];
      end else if (cfg_num == `REG_CLOCK_MULTIPLIER_SETTINGS) begin
        if (!clkmul_locked) begin
          next_clock_multiplier_settings = cfg_wdata & `CMS_WRITE_MASK;
          next_tile_reset  = !cfg_wdata[`CMS_NO_RESET_BIT];
          next_skip_relock = cfg_wdata[`CMS_NO_RELOCK_WAIT_BIT];
        end
      end else if (cfg_num == `REG_SWITCH_CLOCK_DIVIDER) begin
        next_switch_clock_div = cfg_wdata[15:0];
      end else if (cfg_num == `REG_REFERENCE_CLOCK_DIVIDER) begin
        next_reference_clock_div = cfg_wdata[15:0];
      end else if (cfg_num == `REG_ROUTE_DIRECTIONS_LOW) begin
        next_route_directions_low = cfg_wdata;
      end else if (cfg_num == `REG_ROUTE_DIRECTIONS_HIGH) begin
        next_route_directions_high = cfg_wdata;
      end else if (cfg_num == `REG_RESERVED_A) begin
        next_reserved_a = cfg_wdata[1:0];
      end else if (cfg_num == `REG_RESERVED_B) begin
        next_reserved_b = cfg_wdata[1:0];
      end else if (cfg_num == `REG_DEBUG_EVENT_ORIGIN) begin
        next_debug_event_origin = cfg_wdata[4:0] & `DBG_WRITE_MASK;
      end
    end
    // Event applied after the write decode: it overrides a same-cycle software
    // write of the origin, so the latest event is never lost
    if (debug_event) begin
      next_debug_event_origin = {debug_event_origin[4], 2'h0, debug_event_src};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path and access answer

  always_comb begin
    known_num    = 1'b1;
    writable_num = 1'b1;
    next_cfg_rdata = 32'h0000_0000;
    if (cfg_num == `REG_SWITCH_CONFIGURATION) begin
      next_cfg_rdata = switch_configuration;
    end else if (cfg_num == `REG_NODE_IDENTIFIER) begin
      next_cfg_rdata = {16'h0000, node_id};
    end else if (cfg_num == `REG_CLOCK_MULTIPLIER_SETTINGS) begin
      next_cfg_rdata = clock_multiplier_settings;
    end else if (cfg_num == `REG_SWITCH_CLOCK_DIVIDER) begin
      next_cfg_rdata = {16'h0000, switch_clock_div};
    end else if (cfg_num == `REG_REFERENCE_CLOCK_DIVIDER) begin
      next_cfg_rdata = {16'h0000, reference_clock_div};
    end else if (cfg_num == `REG_BOUNDARY_SCAN_DEVICE_ID) begin
      next_cfg_rdata = device_id_code;
      writable_num   = 1'b0;
    end else if (cfg_num == `REG_USER_CODE) begin
      next_cfg_rdata[`UC_OTP_HI:`UC_OTP_LO]     = otp_user_code;
      next_cfg_rdata[`UC_METAL_HI:`UC_METAL_LO] = metal_id_code;
      writable_num = 1'b0;
    end else if (cfg_num == `REG_ROUTE_DIRECTIONS_LOW) begin
      next_cfg_rdata = route_directions_low;
    end else if (cfg_num == `REG_ROUTE_DIRECTIONS_HIGH) begin
      next_cfg_rdata = route_directions_high;
    end else if (cfg_num == `REG_RESERVED_A) begin
      next_cfg_rdata = {30'h0, reserved_a};
    end else if (cfg_num == `REG_RESERVED_B) begin
      next_cfg_rdata = {30'h0, reserved_b};
    end else if (cfg_num == `REG_DEBUG_EVENT_ORIGIN) begin
      next_cfg_rdata = {27'h0, debug_event_origin};
    end else begin
      known_num    = 1'b0;
      writable_num = 1'b0;
    end
    if (!cfg_rd) begin
      next_cfg_rdata = cfg_rdata;
    end
    next_cfg_ack = cfg_rd || cfg_wr;
    // Error flags unknown numbers and writes to read-only registers; a write
    // refused by a lock bit is acked silently as the hardware would.
    next_cfg_err = (cfg_rd && !known_num) || (cfg_wr && !writable_num);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Routing lookup

  direction_t next_route_direction;
  logic       next_route_local;
  node_id_t   mismatch;

  always_comb begin
    mismatch             = dest_node_id ^ node_id;
    next_route_direction = 4'h0;
    next_route_local     = (mismatch == 16'h0000);
    // Later iterations override, so the highest set bit picks the field
    for (int d = 0; d < 8; d++) begin
      if (mismatch[d]) begin
        next_route_direction = route_directions_low[4*d +: 4];
      end
    end
    for (int d = 0; d < 8; d++) begin
      if (mismatch[d+8]) begin
        next_route_direction = route_directions_high[4*d +: 4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      switch_configuration      <= `RST_SWITCH_CONFIGURATION;
      node_id                   <= `RST_NODE_ID;
      clock_multiplier_settings <= `RST_CLOCK_MULTIPLIER;
      switch_clock_div          <= `RST_SWITCH_CLOCK_DIV;
      reference_clock_div       <= `RST_REFERENCE_CLOCK_DIV;
      route_directions_low      <= `RST_DIRECTIONS;
      route_directions_high     <= `RST_DIRECTIONS;
      reserved_a                <= `RST_RESERVED_BITS;
      reserved_b                <= `RST_RESERVED_BITS;
      debug_event_origin        <= `RST_DEBUG_ORIGIN;
      tile_reset                <= 1'b0;
      skip_relock_wait          <= 1'b0;
      cfg_rdata                 <= 32'h0000_0000;
      cfg_ack                   <= 1'b0;
      cfg_err                   <= 1'b0;
      route_direction           <= 4'h0;
      route_local               <= 1'b0;
    end else begin
      switch_configuration      <= next_switch_configuration;
      node_id                   <= next_node_id;
      clock_multiplier_settings <= next_clock_multiplier_settings;
      switch_clock_div          <= next_switch_clock_div;
      reference_clock_div       <= next_reference_clock_div;
      route_directions_low      <= next_route_directions_low;
      route_directions_high     <= next_route_directions_high;
      reserved_a                <= next_reserved_a;
      reserved_b                <= next_reserved_b;
      debug_event_origin        <= next_debug_event_origin;
      tile_reset                <= next_tile_reset;
      skip_relock_wait          <= next_skip_relock;
      cfg_rdata                 <= next_cfg_rdata;
      cfg_ack                   <= next_cfg_ack;
      cfg_err                   <= next_cfg_err;
      route_direction           <= next_route_direction;
      route_local               <= next_route_local;
    end
  end

  // Field views of the settings; each is a flip-flop bit, no logic in between
  assign one_byte_headers  = switch_configuration[`SWCFG_HEADER_BIT];
  assign multiplier_bypass = clock_multiplier_settings[`CMS_BYPASS_BIT];
  assign boot_from_jtag    = clock_multiplier_settings[`CMS_BOOT_JTAG_BIT];
  assign output_divider    = clock_multiplier_settings[`CMS_OD_HI:`CMS_OD_LO];
  assign feedback_ratio    = clock_multiplier_settings[`CMS_F_HI:`CMS_F_LO];
  assign input_divider     = clock_multiplier_settings[`CMS_R_HI:`CMS_R_LO];

endmodule : switch_node_config_regs

/* File: test/switch_node_config_regs_properties.sv */
module switch_node_config_regs_checker (
  // Watched ports
  input wire logic                    ref_clk, rst, cfg_wr, cfg_rd, cfg_ack, cfg_err,
  input wire logic                    tile_reset, one_byte_headers, route_local,
  input wire node_cfg_pkg::reg_num_t  cfg_num,
  input wire node_cfg_pkg::word_t     cfg_wdata,
  input wire node_cfg_pkg::node_id_t  node_id, dest_node_id
);
  import node_cfg_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic w04, w05, w06, lock_seen, pll_lock;
  assign w04 = cfg_wr && cfg_num == 8'h04;
  assign w05 = cfg_wr && cfg_num == 8'h05;
  assign w06 = cfg_wr && cfg_num == 8'h06;
  // Shadow of both lock bits; only reset clears the full lock
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock_seen <= 1'b0;
      pll_lock  <= 1'b0;
    end else if (w04 && !lock_seen) begin
      lock_seen <= cfg_wdata[31];
      pll_lock  <= cfg_wdata[8];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_ack_after_req: assert property ((cfg_wr || cfg_rd) |=> cfg_ack)
    else $error("ack missing after request");
  a_ack_no_req: assert property (!(cfg_wr || cfg_rd) |=> !cfg_ack)
    else $error("ack without request");
  a_tile_reset_cause: assert property (tile_reset |-> $past(w06) && !$past(cfg_wdata[31]))
    else $error("tile reset without cause");
  a_tile_reset_fire: assert property (w06 && !cfg_wdata[31] && !pll_lock && !lock_seen |=> tile_reset)
    else $error("tile reset missing");
  a_clkmul_lock: assert property (w06 && pll_lock |=> !tile_reset)
    else $error("locked multiplier write took effect");
  a_node_id_write: assert property (w05 && !lock_seen |=> node_id == $past(cfg_wdata[15:0]))
    else $error("node id not written");
  a_lock_freezes_id: assert property (lock_seen |=> $stable(node_id))
    else $error("node id changed under lock");
  a_header_write: assert property (w04 && !lock_seen |=> one_byte_headers == $past(cfg_wdata[0]))
    else $error("header mode not written");
  a_route_local: assert property (!$past(rst) |-> route_local == ($past(dest_node_id) == $past(node_id)))
    else $error("local route flag wrong");
  a_ro_write_err: assert property (cfg_wr && (cfg_num == 8'h09 || cfg_num == 8'h0a) |=> cfg_err)
    else $error("read-only write not flagged");
  c_tile_reset: cover property (tile_reset);
  c_route_local: cover property (route_local);
  c_err: cover property (cfg_err);
  c_lock: cover property (lock_seen && w05);
endmodule : switch_node_config_regs_checker

bind switch_node_config_regs switch_node_config_regs_checker i_chk (.ref_clk(ref_clk), .rst(rst),
  .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_ack(cfg_ack), .cfg_err(cfg_err), .tile_reset(tile_reset),
  .one_byte_headers(one_byte_headers), .route_local(route_local), .cfg_num(cfg_num),
  .cfg_wdata(cfg_wdata), .node_id(node_id), .dest_node_id(dest_node_id));

/* File: test/switch_node_config_regs_bench.sv */
`define CHECK_EQ(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end

module switch_node_config_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import node_cfg_pkg::*;
  logic        ref_clk = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, debug_event = 0;
  logic        cfg_ack, cfg_err, route_local, tile_reset, skip_relock_wait, multiplier_bypass;
  logic        boot_from_jtag, one_byte_headers;
  reg_num_t    cfg_num = '0;
  word_t       cfg_wdata = '0, device_id_code = '0, cfg_rdata, q, d, lo, hi, v6;
  logic [13:0] otp_user_code = '0;
  logic [17:0] metal_id_code = '0;
  logic [1:0]  debug_event_src = '0;
  node_id_t    dest_node_id = '0, node_id, idv, x;
  direction_t  route_direction;
  logic [2:0]  output_divider;
  logic [12:0] feedback_ratio;
  logic [6:0]  input_divider;
  logic [15:0] switch_clock_div, reference_clock_div;
  int          n_mismatch = 0, check_count = 0, cycles = 0;
  reg_num_t    nums[10]  = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0c, 8'h0d, 8'h10, 8'h11, 8'h1f};
  // Lock bits of 0x04 are kept out of the random pass and exercised on purpose later
  word_t       masks[10] = '{32'h1, 32'hffff, 32'hf3bf_ff7f, 32'hffff, 32'hffff, '1, '1, 32'h3, 32'h3, 32'h13};

  switch_node_config_regs i_dut (.ref_clk, .rst, .cfg_wr, .cfg_rd, .cfg_num, .cfg_wdata, .cfg_rdata,
    .cfg_ack, .cfg_err, .device_id_code, .otp_user_code, .metal_id_code, .debug_event, .debug_event_src,
    .dest_node_id, .route_direction, .route_local, .one_byte_headers, .node_id, .tile_reset,
    .skip_relock_wait, .multiplier_bypass, .boot_from_jtag, .output_divider, .feedback_ratio,
    .input_divider, .switch_clock_div, .reference_clock_div);

  initial forever #20 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  // One access: request held for exactly one taking edge, answer sampled mid-cycle after it
  task automatic acc(input logic w, input reg_num_t n, input word_t v, input logic e);
    @(posedge ref_clk);
    cfg_wr <= w;
    cfg_rd <= !w;
    cfg_num <= n;
    cfg_wdata <= v;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    @(negedge ref_clk);
    q = cfg_rdata;
    `CHECK_EQ(cfg_ack, 1'b1)
    `CHECK_EQ(cfg_err, e)
  endtask : acc

  function automatic direction_t exp_dir(node_id_t m, word_t l, word_t h);
    direction_t r = '0;
    for (int b = 0; b < 16; b++) if (m[b]) r = (b < 8) ? l[4*b +: 4] : h[4*(b-8) +: 4];
    return r;
  endfunction : exp_dir

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h30f3));
    device_id_code <= $urandom;
    otp_user_code <= 14'($urandom);
    metal_id_code <= 18'($urandom);
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      acc(0, nums[i], '0, 0);
      `CHECK_EQ(q, (i == 4) ? 32'h3 : 32'h0)
    end
    acc(0, 8'h09, '0, 0);
    `CHECK_EQ(q, device_id_code)
    acc(0, 8'h0a, '0, 0);
    `CHECK_EQ(q, {otp_user_code, metal_id_code})
    acc(1, 8'h0a, $urandom, 1);
    acc(0, 8'h0b, '0, 1);
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 10; i++) begin
        d = (i == 0) ? ($urandom & 32'h1) : $urandom;
        acc(1, nums[i], d, 0);
        case (nums[i])
          8'h04: `CHECK_EQ(one_byte_headers, d[0])
          8'h05: `CHECK_EQ(node_id, d[15:0])
          8'h06: begin
            `CHECK_EQ(tile_reset, !d[31])
            `CHECK_EQ({skip_relock_wait, multiplier_bypass, boot_from_jtag}, d[30:28])
            `CHECK_EQ(output_divider, d[25:23])
            `CHECK_EQ(feedback_ratio, d[20:8])
            `CHECK_EQ(input_divider, d[6:0])
          end
          8'h07: `CHECK_EQ(switch_clock_div, d[15:0])
          8'h08: `CHECK_EQ(reference_clock_div, d[15:0])
          default: ;
        endcase
        acc(0, nums[i], '0, 0);
        `CHECK_EQ(q, d & masks[i])
      end
    end
    idv = 16'($urandom);
    lo = $urandom;
    hi = $urandom;
    acc(1, 8'h05, {16'h0, idv}, 0);
    acc(1, 8'h0c, lo, 0);
    acc(1, 8'h0d, hi, 0);
    for (int k = 0; k < 24; k++) begin
      x = (k == 0) ? idv : (k == 1) ? idv ^ 16'h1 : (k == 2) ? idv ^ 16'h8000 : 16'($urandom);
      @(posedge ref_clk);
      dest_node_id <= x;
      @(posedge ref_clk);
      @(negedge ref_clk);
      `CHECK_EQ(route_direction, exp_dir(x ^ idv, lo, hi))
      `CHECK_EQ(route_local, x == idv)
    end
    acc(1, 8'h1f, 32'h10, 0);
    for (int s = 1; s < 4; s++) begin
      @(posedge ref_clk);
      debug_event <= 1'b1;
      debug_event_src <= 2'(s);
      @(posedge ref_clk);
      debug_event <= 1'b0;
      acc(0, 8'h1f, '0, 0);
      `CHECK_EQ(q, 32'h10 | s)
    end
    v6 = $urandom & 32'hf3bf_ff7f;
    acc(1, 8'h06, v6, 0);
    acc(1, 8'h04, 32'h100, 0);
    acc(1, 8'h06, ~v6, 0);
    `CHECK_EQ(tile_reset, 1'b0)
    acc(0, 8'h06, '0, 0);
    `CHECK_EQ(q, v6)
    acc(1, 8'h04, 32'h8000_0001, 0);
    acc(1, 8'h05, {16'h0, ~idv}, 0);
    acc(1, 8'h04, 32'h0, 0);
    acc(0, 8'h05, '0, 0);
    `CHECK_EQ(q, {16'h0, idv})
    acc(0, 8'h04, '0, 0);
    `CHECK_EQ(q, 32'h8000_0001)
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    acc(0, 8'h04, '0, 0);
    `CHECK_EQ(q, 32'h0)
    acc(0, 8'h08, '0, 0);
    `CHECK_EQ(q, 32'h3)
    close_out();
  end
endmodule : switch_node_config_regs_bench
